// ===== design/rtc_supervisor_pkg.sv
// Purpose: constants and types for the rtc supervisor and status block
// Assumes: 100 MHz system clock
// Notes:   long counts are defaults for top-level parameters
package rtc_supervisor_pkg;

   // ==========================================================
   // clock and times
   localparam longint CLK_HZ          = 100_000_000;
   localparam longint MIN_PULSE_NS    = 150;
   localparam longint REC_DEF_MS      = 96;
   localparam longint REC_HALT_MS     = 40;
   localparam longint REC_SHORT_US    = 50;
   localparam longint STARTUP_S       = 1;
   localparam longint BATT_PERIOD_H   = 24;
   localparam int     MIN_PULSE_CYC   = int'((MIN_PULSE_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
   localparam longint REC_DEF_CYC     = REC_DEF_MS * CLK_HZ / 1000;
   localparam longint REC_HALT_CYC    = REC_HALT_MS * CLK_HZ / 1000;
   localparam longint REC_SHORT_CYC   = REC_SHORT_US * CLK_HZ / 1_000_000;
   localparam longint STARTUP_CYC     = STARTUP_S * CLK_HZ;
   localparam longint BATT_PERIOD_CYC = BATT_PERIOD_H * 3600 * CLK_HZ;

   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_IRQEN  = 8'h04;
   localparam logic [7:0] ADDR_WDOG   = 8'h08;
   localparam logic [7:0] ADDR_FLAGS  = 8'h0C;
   localparam logic [7:0] ADDR_CENT   = 8'h10;
   localparam logic [7:0] ADDR_SER_LO = 8'h14;
   localparam logic [7:0] ADDR_SER_HI = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;

   // ==========================================================
   // field positions
   localparam int CTRL_KHZ_EN    = 0;
   localparam int CTRL_HALT      = 1;
   localparam int CTRL_REC_LEN   = 2;
   localparam int CTRL_DRAIN_SEL = 3;
   localparam int CTRL_OUT       = 7;
   localparam int FLAG_OSC_FAIL  = 2;
   localparam int FLAG_BATT_WEAK = 4;

   // ==========================================================
   // reset values (initial power application)
   localparam logic [7:0] CTRL_RST  = 8'h89;
   localparam logic [7:0] IRQEN_RST = 8'h00;
   localparam logic [7:0] WDOG_RST  = 8'h00;

   // arbitrary serial number value, low byte is zero
   localparam logic [63:0] SERIAL_DEF = 64'h5A3C_96E1_0F2D_4B00;

   // ==========================================================
   // types
   typedef enum logic [3:0] {
      SEQ_RUN     = 4'b0001,
      SEQ_HOLD    = 4'b0010,
      SEQ_RECOVER = 4'b0100,
      SEQ_BACKUP  = 4'b1000
   } seq_state_e;

   typedef struct packed {
      logic out_bit;
      logic warn_out_drain_sel;
      logic recovery_len_bit;
      logic osc_halt_bit;
      logic khz_clock_out_enable;
   } ctrl_s;

   typedef struct packed {
      logic tamper_irq_enable_b;
      logic tamper_irq_enable_a;
      logic freq_test_bit;
      logic square_wave_enable;
      logic alarm_backup_enable;
      logic alarm_irq_enable;
      logic osc_fail_irq_enable;
   } irqen_s;

   typedef struct packed {
      logic       wdog_steering;
      logic [4:0] wdog_multiplier;
      logic       wdog_resolution_hi;
      logic       wdog_resolution_lo;
   } wdog_s;

endpackage

// ===== design/rtc_supervisor_reset_status.sv
// Purpose: supervisor, reset and status logic of a serial real-time clock
// Assumes: pin inputs synchronous to clk_i except the two reset inputs
// Notes:   registers on classic wishbone; open-drain pins as level and enable
//
// Functional notes
// - 32 kHz output on when supply ok, running
// - reset low on supply trip, recovery on return
// - power-up clears interrupt, alarm, watchdog enables
// - external resets behave like a power cycle
// - reset pulses below minimum width are ignored
// - input a falling trigger, b rising trigger
// - reset held for recovery time after release
// - warning outputs low while sense input low
// - backup disables comparators, warnings driven low
// - warnings forced high during recovery after return
// - drain select picks open-drain or push-pull warnings
// - century bits increment at year rollover
// - leap day omitted except 400-multiple centuries
// - irq pin mirrors out bit when unused
// - backup enable keeps out pin low in backup
// - battery checked at power-up and every 24h
// - battery flag holds until a passing check
// - recovery length chosen by recovery and halt bits
// - serial number is read-only, eight bytes
// - oscillator fail flag set whenever oscillator stops
// - oscillator fail interrupt and its release
module rtc_supervisor_reset_status #(
   parameter longint REC_DEF_CYC     = rtc_supervisor_pkg::REC_DEF_CYC,
   parameter longint REC_HALT_CYC    = rtc_supervisor_pkg::REC_HALT_CYC,
   parameter longint REC_SHORT_CYC   = rtc_supervisor_pkg::REC_SHORT_CYC,
   parameter longint STARTUP_CYC     = rtc_supervisor_pkg::STARTUP_CYC,
   parameter longint BATT_PERIOD_CYC = rtc_supervisor_pkg::BATT_PERIOD_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // analog front-end status
   input  wire logic        vcc_above_trip_i,
   input  wire logic        vcc_above_switchover_i,
   input  wire logic        osc_running_i,
   input  wire logic        osc_clk_level_i,
   input  wire logic        battery_ok_i,
   input  wire logic        sense_low_a_i,
   input  wire logic        sense_low_b_i,
   // calendar hooks
   input  wire logic        year_rollover_i,
   output logic             leap_day_ok_o,
   // reset inputs
   input  wire logic        ext_reset_in_a_n_i,
   input  wire logic        ext_reset_in_b_i,
   // pins
   output logic             khz_clock_out_pin_o,
   output logic             khz_clock_out_pin_oe_o,
   output logic             reset_out_n_o,
   output logic             reset_out_n_oe_o,
   output logic             supply_warn_out_a_n_o,
   output logic             supply_warn_out_a_n_oe_o,
   output logic             supply_warn_out_b_n_o,
   output logic             supply_warn_out_b_n_oe_o,
   output logic             irq_out_n_o,
   output logic             irq_out_n_oe_o
);

   // ==========================================================
   // state
   rtc_supervisor_pkg::ctrl_s      ctrl_r;
   rtc_supervisor_pkg::irqen_s     irqen_r;
   rtc_supervisor_pkg::wdog_s      wdog_r;
   rtc_supervisor_pkg::seq_state_e seq_r;
   rtc_supervisor_pkg::seq_state_e seq_nxt;
   logic [1:0]  century_r;
   logic        osc_fail_r;
   logic        batt_weak_r;
   logic        pwr_rec_r;
   logic [63:0] rec_cnt_r;
   logic [63:0] startup_cnt_r;
   logic [63:0] batt_cnt_r;
   logic        startup_done_r;
   logic [1:0]  sync_a_r;
   logic [1:0]  sync_b_r;
   logic [7:0]  pulse_a_r;
   logic [7:0]  pulse_b_r;
   logic        ack_r;
   logic [31:0] dat_r;

   // ==========================================================
   // bus decode
   wire bus_req   = cyc_i & stb_i & ~ack_r;
   wire bus_wr    = bus_req & we_i & sel_i[0];
   wire wr_ctrl   = bus_wr & (adr_i == rtc_supervisor_pkg::ADDR_CTRL);
   wire wr_irqen  = bus_wr & (adr_i == rtc_supervisor_pkg::ADDR_IRQEN);
   wire wr_wdog   = bus_wr & (adr_i == rtc_supervisor_pkg::ADDR_WDOG);
   wire wr_flags  = bus_wr & (adr_i == rtc_supervisor_pkg::ADDR_FLAGS);
   wire wr_cent   = bus_wr & (adr_i == rtc_supervisor_pkg::ADDR_CENT);

   // ==========================================================
   // reset input filters
   wire a_low     = ~sync_a_r[1];
   wire b_high    = sync_b_r[1];
   wire qual_a    = (pulse_a_r >= 8'(rtc_supervisor_pkg::MIN_PULSE_CYC));
   wire qual_b    = (pulse_b_r >= 8'(rtc_supervisor_pkg::MIN_PULSE_CYC));
   wire ext_act   = qual_a | qual_b;

   function automatic logic [7:0] pulse_count(input logic active, input logic [7:0] cnt);
      logic [7:0] r;
      r = 8'h00;
      if (active) begin
         r = (cnt == 8'hFF) ? cnt : cnt + 8'h01;
      end
      return r;
   endfunction

   // ==========================================================
   // sequencer
   wire vcc_ok    = vcc_above_trip_i;
   wire rec_done  = (rec_cnt_r == 64'h0);
   wire rec_short = ctrl_r.recovery_len_bit;
   wire [63:0] rec_len = rec_short ? 64'(REC_SHORT_CYC) :
                         ctrl_r.osc_halt_bit ? 64'(REC_HALT_CYC) : 64'(REC_DEF_CYC);
   wire in_backup = (seq_r == rtc_supervisor_pkg::SEQ_BACKUP);

   always_comb begin
      seq_nxt = seq_r;
      case (seq_r)
         rtc_supervisor_pkg::SEQ_RUN: begin
            if (!vcc_ok) begin
               seq_nxt = rtc_supervisor_pkg::SEQ_BACKUP;
            end else if (ext_act) begin
               seq_nxt = rtc_supervisor_pkg::SEQ_HOLD;
            end
         end
         rtc_supervisor_pkg::SEQ_HOLD: begin
            if (!vcc_ok) begin
               seq_nxt = rtc_supervisor_pkg::SEQ_BACKUP;
            end else if (!ext_act) begin
               seq_nxt = rtc_supervisor_pkg::SEQ_RECOVER;
            end
         end
         rtc_supervisor_pkg::SEQ_RECOVER: begin
            if (!vcc_ok) begin
               seq_nxt = rtc_supervisor_pkg::SEQ_BACKUP;
            end else if (ext_act) begin
               seq_nxt = rtc_supervisor_pkg::SEQ_HOLD;
            end else if (rec_done) begin
               seq_nxt = rtc_supervisor_pkg::SEQ_RUN;
            end
         end
         rtc_supervisor_pkg::SEQ_BACKUP: begin
            if (vcc_ok) begin
               seq_nxt = rtc_supervisor_pkg::SEQ_RECOVER;
            end
         end
         default: seq_nxt = rtc_supervisor_pkg::SEQ_BACKUP;
      endcase
   end

   wire pwr_return  = in_backup & vcc_ok;
   wire enter_hold  = (seq_nxt == rtc_supervisor_pkg::SEQ_HOLD) & (seq_r != rtc_supervisor_pkg::SEQ_HOLD);
   wire clear_bits  = pwr_return | enter_hold;
   wire rec_load    = (seq_nxt == rtc_supervisor_pkg::SEQ_RECOVER) &
                      (seq_r != rtc_supervisor_pkg::SEQ_RECOVER);
   wire reset_act   = (seq_r != rtc_supervisor_pkg::SEQ_RUN);

   // ==========================================================
   // battery check, only with supply nominal
   wire batt_tick   = (batt_cnt_r >= 64'(BATT_PERIOD_CYC) - 64'h1);
   wire batt_check  = pwr_return | (vcc_ok & ~in_backup & batt_tick);

   // ==========================================================
   // oscillator fail and interrupt pin
   wire osc_stop    = ~osc_running_i | ctrl_r.osc_halt_bit;
   wire of_clear    = wr_flags & ~dat_i[rtc_supervisor_pkg::FLAG_OSC_FAIL];
   wire wdog_irq    = ~wdog_r.wdog_steering & (wdog_r.wdog_multiplier != 5'h00);
   wire any_irq_en  = irqen_r.osc_fail_irq_enable | irqen_r.alarm_irq_enable |
                      irqen_r.tamper_irq_enable_a | irqen_r.tamper_irq_enable_b | wdog_irq;
   // reset assertion releases the pin; reading the flags has no effect on it
   wire of_irq      = irqen_r.osc_fail_irq_enable & osc_fail_r & ~reset_act &
                      (~in_backup | irqen_r.alarm_backup_enable);
   wire out_low     = ~any_irq_en & ~ctrl_r.out_bit &
                      (~in_backup | irqen_r.alarm_backup_enable);
   wire irq_low     = of_irq | out_low;

   // ==========================================================
   // warnings
   wire comp_en     = (seq_r != rtc_supervisor_pkg::SEQ_BACKUP) & ~pwr_rec_r;
   wire warn_a      = in_backup ? 1'b0 : (comp_en ? ~sense_low_a_i : 1'b1);
   wire warn_b      = in_backup ? 1'b0 : (comp_en ? ~sense_low_b_i : 1'b1);

   // ==========================================================
   // 32 kHz pin
   wire khz_on      = vcc_above_switchover_i & ~ctrl_r.osc_halt_bit &
                      ctrl_r.khz_clock_out_enable & startup_done_r;

   // ==========================================================
   // read mux
   wire [31:0] rd_data =
      (adr_i == rtc_supervisor_pkg::ADDR_CTRL)   ? {24'h0, ctrl_r.out_bit, 3'h0, ctrl_r[3:0]} :
      (adr_i == rtc_supervisor_pkg::ADDR_IRQEN)  ? {25'h0, irqen_r} :
      (adr_i == rtc_supervisor_pkg::ADDR_WDOG)   ? {24'h0, wdog_r} :
      (adr_i == rtc_supervisor_pkg::ADDR_FLAGS)  ? {27'h0, batt_weak_r, 1'b0, osc_fail_r, 2'h0} :
      (adr_i == rtc_supervisor_pkg::ADDR_CENT)   ? {30'h0, century_r} :
      (adr_i == rtc_supervisor_pkg::ADDR_SER_LO) ? rtc_supervisor_pkg::SERIAL_DEF[31:0] :
      (adr_i == rtc_supervisor_pkg::ADDR_SER_HI) ? rtc_supervisor_pkg::SERIAL_DEF[63:32] :
      (adr_i == rtc_supervisor_pkg::ADDR_STATUS) ? {26'h0, warn_b, warn_a, irq_low,
                                                    reset_act, in_backup, vcc_ok} :
      32'h0;

   // leap day in a century year only with century bits zero; plain years are left to the calendar
   wire leap_ok = (century_r == 2'h0);

   // ==========================================================
   // bus registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0;
      end else begin
         ack_r <= bus_req;
         dat_r <= bus_req ? rd_data : 32'h0;
      end
   end

   // ==========================================================
   // control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r  <= rtc_supervisor_pkg::ctrl_s'({rtc_supervisor_pkg::CTRL_RST[7],
                                                 rtc_supervisor_pkg::CTRL_RST[3:0]});
         irqen_r <= rtc_supervisor_pkg::irqen_s'(rtc_supervisor_pkg::IRQEN_RST[6:0]);
         wdog_r  <= rtc_supervisor_pkg::wdog_s'(rtc_supervisor_pkg::WDOG_RST);
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= rtc_supervisor_pkg::ctrl_s'({dat_i[rtc_supervisor_pkg::CTRL_OUT], dat_i[3:0]});
         end
         if (clear_bits) begin
            irqen_r <= rtc_supervisor_pkg::irqen_s'(rtc_supervisor_pkg::IRQEN_RST[6:0]);
            wdog_r  <= rtc_supervisor_pkg::wdog_s'(rtc_supervisor_pkg::WDOG_RST);
         end else begin
            if (wr_irqen) begin
               irqen_r <= rtc_supervisor_pkg::irqen_s'(dat_i[6:0]);
            end
            if (wr_wdog) begin
               wdog_r <= rtc_supervisor_pkg::wdog_s'(dat_i[7:0]);
            end
         end
      end
   end

   // ==========================================================
   // flags and century
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_fail_r  <= 1'b1;
         batt_weak_r <= 1'b0;
         century_r   <= 2'h0;
      end else begin
         // a stop in the clearing cycle wins over the clear
         if (osc_stop) begin
            osc_fail_r <= 1'b1;
         end else if (of_clear) begin
            osc_fail_r <= 1'b0;
         end
         if (batt_check) begin
            batt_weak_r <= ~battery_ok_i;
         end
         if (year_rollover_i) begin
            century_r <= century_r + 2'h1;
         end else if (wr_cent) begin
            century_r <= dat_i[1:0];
         end
      end
   end

   // ==========================================================
   // sequencer and counters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_r     <= rtc_supervisor_pkg::SEQ_BACKUP;
         rec_cnt_r <= 64'h0;
         pwr_rec_r <= 1'b0;
         batt_cnt_r <= 64'h0;
      end else begin
         seq_r <= seq_nxt;
         if (rec_load) begin
            rec_cnt_r <= rec_len - 64'h1;
         end else if (!rec_done) begin
            rec_cnt_r <= rec_cnt_r - 64'h1;
         end
         if (pwr_return) begin
            pwr_rec_r <= 1'b1;
         end else if (seq_r == rtc_supervisor_pkg::SEQ_RUN) begin
            pwr_rec_r <= 1'b0;
         end
         if (pwr_return || batt_tick || in_backup) begin
            batt_cnt_r <= 64'h0;
         end else begin
            batt_cnt_r <= batt_cnt_r + 64'h1;
         end
      end
   end

   // ==========================================================
   // reset input sync and width filters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_a_r  <= 2'b11;
         sync_b_r  <= 2'b00;
         pulse_a_r <= 8'h00;
         pulse_b_r <= 8'h00;
      end else begin
         sync_a_r  <= {sync_a_r[0], ext_reset_in_a_n_i};
         sync_b_r  <= {sync_b_r[0], ext_reset_in_b_i};
         pulse_a_r <= pulse_count(a_low, pulse_a_r);
         pulse_b_r <= pulse_count(b_high, pulse_b_r);
      end
   end

   // ==========================================================
   // startup delay for the 32 kHz pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         startup_cnt_r  <= 64'h0;
         startup_done_r <= 1'b0;
      end else if (!startup_done_r) begin
         startup_cnt_r  <= startup_cnt_r + 64'h1;
         startup_done_r <= (startup_cnt_r >= 64'(STARTUP_CYC) - 64'h1);
      end
   end

   // ==========================================================
   // pin registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         khz_clock_out_pin_o      <= 1'b0;
         khz_clock_out_pin_oe_o   <= 1'b0;
         reset_out_n_o            <= 1'b0;
         reset_out_n_oe_o         <= 1'b1;
         supply_warn_out_a_n_o    <= 1'b0;
         supply_warn_out_a_n_oe_o <= 1'b1;
         supply_warn_out_b_n_o    <= 1'b0;
         supply_warn_out_b_n_oe_o <= 1'b1;
         irq_out_n_o              <= 1'b0;
         irq_out_n_oe_o           <= 1'b0;
         leap_day_ok_o            <= 1'b0;
      end else begin
         // open drain: high is released, pull-up gives the level
         khz_clock_out_pin_o      <= 1'b0;
         khz_clock_out_pin_oe_o   <= khz_on & ~osc_clk_level_i;
         reset_out_n_o            <= 1'b0;
         reset_out_n_oe_o         <= (seq_nxt != rtc_supervisor_pkg::SEQ_RUN);
         supply_warn_out_a_n_o    <= warn_a;
         supply_warn_out_a_n_oe_o <= ctrl_r.warn_out_drain_sel ? ~warn_a : 1'b1;
         supply_warn_out_b_n_o    <= warn_b;
         supply_warn_out_b_n_oe_o <= ctrl_r.warn_out_drain_sel ? ~warn_b : 1'b1;
         irq_out_n_o              <= 1'b0;
         irq_out_n_oe_o           <= irq_low;
         leap_day_ok_o            <= leap_ok;
      end
   end

   assign ack_o = ack_r;
   assign dat_o = dat_r;

endmodule

// ===== tb/host_pins.sv
// Purpose: host side of the open-drain pins
// Assumes: pull-ups on every open-drain line
// Notes:   a released line reads as the pull-up level
module host_pins (
   input  wire logic reset_oe_i,
   input  wire logic warn_i,
   input  wire logic warn_oe_i,
   input  wire logic irq_oe_i,
   output logic      reset_pin_o,
   output logic      warn_pin_o,
   output logic      irq_pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   assign reset_pin_o = !reset_oe_i;
   assign warn_pin_o  = warn_oe_i ? warn_i : 1'b1;
   assign irq_pin_o   = !irq_oe_i;
endmodule

// ===== tb/rtc_supervisor_reset_status_tb.sv
// Purpose: self-checking bench for the supervisor block
// Assumes: short recovery counts set below
// Notes:   recovery lengths allow a few cycles of sync latency
module rtc_supervisor_reset_status_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, year_rollover_i = 1'b0;
   logic vcc_above_trip_i = 1'b1, vcc_above_switchover_i = 1'b1, osc_running_i = 1'b1, osc_clk_level_i = 1'b0;
   logic battery_ok_i = 1'b1, sense_low_a_i = 1'b0, sense_low_b_i = 1'b0, ext_reset_in_a_n_i = 1'b1;
   logic ext_reset_in_b_i = 1'b0, rst_pin, warn_a_pin, irq_pin;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic ack_o, leap_day_ok_o, khz_clock_out_pin_o, khz_clock_out_pin_oe_o, reset_out_n_o, reset_out_n_oe_o;
   logic supply_warn_out_a_n_o, supply_warn_out_a_n_oe_o, supply_warn_out_b_n_o, supply_warn_out_b_n_oe_o;
   logic irq_out_n_o, irq_out_n_oe_o;
   int fail_count = 0, n_checks = 0, ticks = 0;
   rtc_supervisor_reset_status #(.REC_DEF_CYC(200), .REC_HALT_CYC(100), .REC_SHORT_CYC(20),
      .STARTUP_CYC(50), .BATT_PERIOD_CYC(500)) DUT (.*);
   host_pins hp (.reset_oe_i(reset_out_n_oe_o), .warn_i(supply_warn_out_a_n_o), .warn_oe_i(supply_warn_out_a_n_oe_o),
      .irq_oe_i(irq_out_n_oe_o), .reset_pin_o(rst_pin), .warn_pin_o(warn_a_pin), .irq_pin_o(irq_pin));
   // ==========================================================
   // infrastructure
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      ticks++;
      if (ticks == 12000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkb(input string nm, input logic e, input logic g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // wishbone classic single cycle; read data lands in q
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic rec_len(output int n);
      n = 0;
      while (rst_pin !== 1'b1) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   // ==========================================================
   // scenarios
   task automatic t_ext();
      logic [7:0] a[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
      logic [7:0] e[6] = '{8'h89, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00};
      logic [7:0] c[3] = '{8'h89, 8'h8B, 8'h8D};
      int l[4] = '{200, 200, 100, 20};
      int n;
      rec_len(n);
      chkb("cold recovery", 1'b1, n >= l[0] && n <= l[0] + 6);
      foreach (a[i]) begin
         wb(1'b0, a[i], 32'h0);
         chk("cold register", {24'h0, e[i]}, q);
      end
      ext_reset_in_a_n_i <= 1'b0;
      idle(6);
      ext_reset_in_a_n_i <= 1'b1;
      idle(20);
      chkb("short pulse", 1'b1, rst_pin);
      foreach (c[i]) begin
         wb(1'b1, 8'h00, {24'h0, c[i]});
         wb(1'b1, 8'h08, 32'hFF);
         if (i == 0)
            ext_reset_in_a_n_i <= 1'b0;
         else
            ext_reset_in_b_i <= 1'b1;
         idle(30);
         chkb("reset held", 1'b0, rst_pin);
         ext_reset_in_a_n_i <= 1'b1;
         ext_reset_in_b_i <= 1'b0;
         rec_len(n);
         chkb("recovery", 1'b1, n >= l[i + 1] && n <= l[i + 1] + 6);
         wb(1'b0, 8'h08, 32'h0);
         chk("wdog cleared", 32'h0, q);
      end
      wb(1'b1, 8'h00, 32'h89);
   endtask
   task automatic t_supply();
      int n;
      chkb("open drain released", 1'b0, supply_warn_out_a_n_oe_o);
      chkb("khz driven", 1'b1, khz_clock_out_pin_oe_o);
      wb(1'b1, 8'h00, 32'h81);
      idle(1);
      chkb("push-pull driven", 1'b1, supply_warn_out_a_n_oe_o);
      wb(1'b1, 8'h00, 32'h89);
      sense_low_a_i <= 1'b1;
      idle(4);
      chkb("warn a", 1'b0, warn_a_pin);
      chkb("warn b", 1'b1, supply_warn_out_b_n_o);
      sense_low_a_i <= 1'b0;
      vcc_above_trip_i <= 1'b0;
      vcc_above_switchover_i <= 1'b0;
      idle(4);
      chkb("backup reset", 1'b0, rst_pin);
      chkb("backup warn", 1'b0, warn_a_pin);
      chkb("khz backup", 1'b0, khz_clock_out_pin_oe_o);
      wb(1'b0, 8'h1C, 32'h0);
      chk("status backup", 32'h06, q);
      sense_low_a_i <= 1'b1;
      vcc_above_trip_i <= 1'b1;
      vcc_above_switchover_i <= 1'b1;
      idle(4);
      chkb("warn forced", 1'b1, supply_warn_out_a_n_o);
      rec_len(n);
      chkb("return recovery", 1'b1, n >= 196 && n <= 202);
      idle(3);
      chkb("warn follows", 1'b0, supply_warn_out_a_n_o);
      sense_low_a_i <= 1'b0;
   endtask
   task automatic t_flags();
      chkb("leap zero", 1'b1, leap_day_ok_o);
      year_rollover_i <= 1'b1;
      idle(1);
      year_rollover_i <= 1'b0;
      wb(1'b0, 8'h10, 32'h0);
      chk("century", 32'h1, q);
      chkb("leap", 1'b0, leap_day_ok_o);
      wb(1'b1, 8'h14, 32'h0);
      wb(1'b0, 8'h14, 32'h0);
      chk("serial", rtc_supervisor_pkg::SERIAL_DEF[31:0], q);
      wb(1'b0, 8'h18, 32'h0);
      chk("serial high", rtc_supervisor_pkg::SERIAL_DEF[63:32], q);
      wb(1'b1, 8'h0C, 32'h0);
      osc_running_i <= 1'b0;
      idle(3);
      osc_running_i <= 1'b1;
      wb(1'b1, 8'h04, 32'h01);
      wb(1'b0, 8'h0C, 32'h0);
      chk("osc fail", 32'h04, q);
      chkb("irq after read", 1'b0, irq_pin);
      wb(1'b1, 8'h0C, 32'h0);
      idle(2);
      chkb("irq released", 1'b1, irq_pin);
      wb(1'b1, 8'h04, 32'h0);
      wb(1'b1, 8'h00, 32'h09);
      idle(2);
      chkb("out bit low", 1'b0, irq_pin);
      wb(1'b1, 8'h00, 32'h89);
      battery_ok_i <= 1'b0;
      idle(520);
      wb(1'b0, 8'h0C, 32'h0);
      chk("battery weak", 32'h10, q);
      battery_ok_i <= 1'b1;
      idle(520);
      wb(1'b0, 8'h0C, 32'h0);
      chk("battery cleared", 32'h0, q);
   endtask
   initial begin
      idle(3);
      rst_i <= 1'b0;
      t_ext();
      t_supply();
      t_flags();
      wrap_up();
   end
endmodule

// ===== tb/rtc_supervisor_sva.sv
// Purpose: pin-level assertions for the supervisor block
// Assumes: bench runs the short recovery counts
// Notes:   recovery bounds are minima only, lengths to within six cycles are checked by the bench
module rtc_supervisor_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic vcc_above_trip_i,
   input wire logic vcc_above_switchover_i,
   input wire logic sense_low_a_i,
   input wire logic ext_reset_in_a_n_i,
   input wire logic ext_reset_in_b_i,
   input wire logic khz_clock_out_pin_oe_o,
   input wire logic reset_out_n_oe_o,
   input wire logic supply_warn_out_a_n_o,
   input wire logic supply_warn_out_a_n_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] run_r;
   logic [7:0] rel_r;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ==========================================================
   // helpers: low run of input a, reset time after inputs released
   always_ff @(posedge clk_i) begin
      run_r <= (rst_i || ext_reset_in_a_n_i) ? 8'h00 : run_r + {7'h00, run_r != 8'hFF};
      rel_r <= (rst_i || !reset_out_n_oe_o || !ext_reset_in_a_n_i || ext_reset_in_b_i) ? 8'h00
               : rel_r + {7'h00, rel_r != 8'hFF};
   end
   // ==========================================================
   // assertions
   AST_TRIP: assert property (!vcc_above_trip_i [*2] |-> reset_out_n_oe_o)
      else $error("reset not asserted below trip level");
   AST_SHORT: assert property ($rose(ext_reset_in_a_n_i) && run_r < 8'h0C && !reset_out_n_oe_o
      && vcc_above_trip_i && !ext_reset_in_b_i |-> !reset_out_n_oe_o [*8])
      else $error("short reset pulse produced a reset");
   AST_REC: assert property ($fell(reset_out_n_oe_o) |-> rel_r >= 8'h0F)
      else $error("reset released before recovery time");
   AST_BKUP: assert property (!vcc_above_trip_i [*3] |-> !supply_warn_out_a_n_o && supply_warn_out_a_n_oe_o)
      else $error("warning not driven low in backup");
   AST_FORCE: assert property ($rose(vcc_above_trip_i) |-> ##2 supply_warn_out_a_n_o [*8])
      else $error("warning not forced high after supply return");
   AST_FOLLOW: assert property ((!reset_out_n_oe_o && vcc_above_trip_i && $stable(sense_low_a_i)) [*3]
      |-> supply_warn_out_a_n_o == !sense_low_a_i)
      else $error("warning does not follow sense input");
   AST_DRAIN: assert property (supply_warn_out_a_n_o || supply_warn_out_a_n_oe_o)
      else $error("low warning level not driven");
   AST_KHZ: assert property (!vcc_above_switchover_i [*2] |-> !khz_clock_out_pin_oe_o)
      else $error("clock output active below switchover");
   cover property ($fell(reset_out_n_oe_o));
   cover property ($rose(vcc_above_trip_i));
   cover property ($rose(khz_clock_out_pin_oe_o));
endmodule

bind rtc_supervisor_reset_status rtc_supervisor_sva chk (.*);
